// ===== verilog/swi_sleep_wake_inhibit_control.sv
`timescale 1ns/10ps
`default_nettype none
module swi_sleep_wake_inhibit_control (
    // Clock and reset.
    input  wire logic core_clk,
    input  wire logic arst_n,
    // Mode control from the mode logic.
    input  wire logic sleep_req,
    input  wire logic standby_req,
    input  wire logic wake_flag_clear,
    input  wire logic edge_mode_one,
    input  wire logic edge_rising,
    // Wake sources.
    input  wire logic pin_triggered_rouse,
    input  wire logic bus_rouse_pattern,
    // Controller side.
    input  wire logic txd_in,
    input  wire logic txd_valid,
    input  wire logic bus_rx_level,
    output var  logic rxd_out,
    output var  logic txd_to_driver,
    // Power control.
    output var  logic system_power_enable_out,
    output var  logic system_power_enable_oe,
    output var  logic regulator_enable,
    output var  logic bus_monitor_enable,
    output var  logic wake_pending,
    output var  swi_pkg::swi_mode_e mode_state
);
    swi_pkg::swi_mode_e mode_reg;
    swi_pkg::swi_mode_e mode_next;
    // Synchronised wake inputs.
    logic lwu_sync;
    logic bus_sync;
    // Registered state and next values.
    logic lwu_prev_reg;
    logic lwu_prev_next;
    logic wake_reg;
    logic wake_next;
    logic reg_en_reg;
    logic reg_en_next;
    logic rxd_reg;
    logic rxd_next;
    logic txd_reg;
    logic txd_next;
    // Combinational wake decode.
    logic lwu_edge;
    logic wake_event;

    // Both pins arrive asynchronously.
    swi_sync u_lwu_sync (
        .core_clk  (core_clk),
        .arst_n    (arst_n),
        .async_in  (pin_triggered_rouse),
        .rst_level (1'b0),
        .sync_out  (lwu_sync)
    );

    // The bus wake detector runs in its own domain as well.
    swi_sync u_bus_sync (
        .core_clk  (core_clk),
        .arst_n    (arst_n),
        .async_in  (bus_rouse_pattern),
        .rst_level (1'b0),
        .sync_out  (bus_sync)
    );

    always_comb begin
        lwu_prev_next = lwu_sync;
        if (edge_mode_one == swi_pkg::SWI_EDGE_BOTH) begin
            lwu_edge = lwu_sync ^ lwu_prev_reg;
        end else if (edge_rising) begin
            lwu_edge = lwu_sync & ~lwu_prev_reg;
        end else begin
            lwu_edge = ~lwu_sync & lwu_prev_reg;
        end
        // Bus monitoring stays live in sleep; only sleep wakes count.
        wake_event = (mode_reg == swi_pkg::SWI_MODE_SLEEP) &&
                     (lwu_edge || bus_sync);
    end

    // Reset level matches the synchroniser so no false edge follows reset.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            lwu_prev_reg <= 1'b0;
        end else begin
            lwu_prev_reg <= lwu_prev_next;
        end
    end

    // Wakes land in standby; the controller chooses normal itself.
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            swi_pkg::SWI_MODE_NORMAL,
            swi_pkg::SWI_MODE_STANDBY: begin
                if (sleep_req) begin
                    mode_next = swi_pkg::SWI_MODE_SLEEP;
                end else if (standby_req) begin
                    mode_next = swi_pkg::SWI_MODE_STANDBY;
                end else begin
                    mode_next = swi_pkg::SWI_MODE_NORMAL;
                end
            end
            swi_pkg::SWI_MODE_SLEEP: begin
                // One cycle to wake keeps power-up far inside 50 us.
                if (wake_event) begin
                    mode_next = swi_pkg::SWI_MODE_STANDBY;
                end
            end
            default: begin
                mode_next = swi_pkg::SWI_MODE_STANDBY;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg <= swi_pkg::SWI_MODE_STANDBY;
        end else begin
            mode_reg <= mode_next;
        end
    end

    always_comb begin
        // Set wins over clear so a wake in the clear cycle is kept.
        if (wake_event) begin
            wake_next = 1'b1;
        end else if (wake_flag_clear) begin
            wake_next = 1'b0;
        end else begin
            wake_next = wake_reg;
        end
    end

    // The flag outlives the wake so a slow controller still sees it.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= wake_next;
        end
    end

    // Keyed off the next mode so the regulator turns with the mode.
    always_comb begin
        reg_en_next = (mode_next != swi_pkg::SWI_MODE_SLEEP);
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_en_reg <= 1'b1;
        end else begin
            reg_en_reg <= reg_en_next;
        end
    end

    // A pending wake outranks the bus level so the output holds low.
    always_comb begin
        if (wake_next) begin
            rxd_next = swi_pkg::SWI_LEVEL_DOMINANT;
        end else if (mode_next == swi_pkg::SWI_MODE_SLEEP) begin
            rxd_next = swi_pkg::SWI_LEVEL_RECESSIVE;
        end else begin
            rxd_next = bus_rx_level;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rxd_reg <= swi_pkg::SWI_LEVEL_RECESSIVE;
        end else begin
            rxd_reg <= rxd_next;
        end
    end

    always_comb begin
        // Floating or unpowered input resolves to recessive.
        txd_next = txd_valid ? txd_in : swi_pkg::SWI_LEVEL_RECESSIVE;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            txd_reg <= swi_pkg::SWI_LEVEL_RECESSIVE;
        end else begin
            txd_reg <= txd_next;
        end
    end

    // The pin only ever drives high; release lets the load pull it low.
    assign system_power_enable_out = 1'b1;
    assign system_power_enable_oe  =
        (mode_reg != swi_pkg::SWI_MODE_SLEEP);
    assign regulator_enable   = reg_en_reg;
    assign bus_monitor_enable = 1'b1;
    assign rxd_out            = rxd_reg;
    assign txd_to_driver      = txd_reg;
    assign wake_pending       = wake_reg;
    assign mode_state         = mode_reg;
endmodule : swi_sleep_wake_inhibit_control
`default_nettype wire

// ===== verilog/swi_pkg.sv
`default_nettype none
package swi_pkg;
    typedef enum logic [1:0] {
        SWI_MODE_NORMAL,
        SWI_MODE_STANDBY,
        SWI_MODE_SLEEP
    } swi_mode_e;

    localparam int  SWI_CLK_FREQ_HZ       = 100_000_000;
    localparam int  SWI_WAKE_TO_POWER_US  = 50;
    localparam int  SWI_WAKE_TO_POWER_CYC =
        (SWI_CLK_FREQ_HZ / 1_000_000) * SWI_WAKE_TO_POWER_US;
    localparam int  SWI_SYNC_STAGES       = 2;
    localparam logic SWI_LEVEL_RECESSIVE  = 1'b1;
    localparam logic SWI_LEVEL_DOMINANT   = 1'b0;
    localparam logic SWI_EDGE_BOTH        = 1'b0;
    localparam logic SWI_EDGE_ONE         = 1'b1;
    localparam logic [1:0] SWI_SYNC_RESET = 2'h0;
endpackage : swi_pkg
`default_nettype wire

// ===== verilog/swi_sync.sv
`timescale 1ns/10ps
`default_nettype none
module swi_sync (
    // Clock and reset.
    input  wire logic core_clk,
    input  wire logic arst_n,
    // Level in and out.
    input  wire logic async_in,
    input  wire logic rst_level,
    output var  logic sync_out
);
    logic [1:0] stage_reg;
    logic [1:0] stage_next;

    always_comb begin
        stage_next = {stage_reg[0], async_in};
    end

    // Reset value is a constant; the pin level is taken on later edges.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            stage_reg <= swi_pkg::SWI_SYNC_RESET;
        end else begin
            stage_reg <= stage_next;
        end
    end

    assign sync_out = stage_reg[1];
endmodule : swi_sync
`default_nettype wire

// ===== verif/swi_chk.sv
`timescale 1ns/10ps
`default_nettype none
module swi_chk (
    // Inputs.
    input wire logic core_clk, arst_n, edge_mode_one,
    input wire logic pin_triggered_rouse, bus_rouse_pattern,
    input wire logic txd_in, txd_valid,
    // Outputs.
    input wire logic rxd_out, txd_to_driver, regulator_enable,
    input wire logic system_power_enable_out, wake_pending,
    input wire logic system_power_enable_oe, bus_monitor_enable,
    input wire swi_pkg::swi_mode_e mode_state
);
    wire logic s = mode_state == swi_pkg::SWI_MODE_SLEEP;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    property p_oe; system_power_enable_oe == !s; endproperty
    a_oe: assert property (p_oe) else $error("oe");
    property p_hi; system_power_enable_out; endproperty
    a_hi: assert property (p_hi) else $error("low");
    property p_bus; s && bus_rouse_pattern |-> ##[1:5] !s; endproperty
    a_bus: assert property (p_bus) else $error("bus");
    property p_reg; s |-> !regulator_enable; endproperty
    a_reg: assert property (p_reg) else $error("reg");
    property p_up; $fell(s) |-> regulator_enable; endproperty
    a_up: assert property (p_up) else $error("up");
    property p_rxd; $rose(wake_pending) |-> !rxd_out; endproperty
    a_rxd: assert property (p_rxd) else $error("rxd");
    property p_pin; s && !edge_mode_one && $changed(pin_triggered_rouse)
        |-> ##[1:5] !s; endproperty
    a_pin: assert property (p_pin) else $error("pin");
    property p_mon; s |-> bus_monitor_enable; endproperty
    a_mon: assert property (p_mon) else $error("mon");
    property p_txd; txd_to_driver ==
        ($past(txd_valid) ? $past(txd_in) : 1'b1); endproperty
    a_txd: assert property (p_txd) else $error("txd");
    cover property ($rose(s));
    cover property ($rose(wake_pending));
    cover property (txd_valid && !txd_in);
endmodule : swi_chk
bind swi_sleep_wake_inhibit_control swi_chk i_chk (.*);
`default_nettype wire

// ===== verif/swi_partner.sv
`timescale 1ns/10ps
`default_nettype none
module swi_partner (
    // Enable pin from the block.
    input wire logic system_power_enable_out, system_power_enable_oe,
    // Enable as the supplies see it.
    output logic rail_on
);
    // A pull-down holds the released pin low.
    assign rail_on = system_power_enable_oe & system_power_enable_out;
endmodule : swi_partner
`default_nettype wire

// ===== verif/swi_sleep_wake_inhibit_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module swi_sleep_wake_inhibit_control_bench;
    logic core_clk, arst_n, sleep_req, standby_req, wake_flag_clear;
    logic edge_mode_one, edge_rising, pin_triggered_rouse, rail_on;
    logic bus_rouse_pattern, txd_in, txd_valid, bus_rx_level;
    logic rxd_out, txd_to_driver, system_power_enable_out;
    logic system_power_enable_oe, regulator_enable, wake_pending;
    swi_pkg::swi_mode_e mode_state;
    logic [5:0] exp_q[$];
    logic [5:0] e;
    logic [31:0] r = 32'hcf05_4584;
    int mismatches = 0, comparisons = 0, n;
    wire logic [5:0] obs = {system_power_enable_oe, rail_on,
        regulator_enable, rxd_out, wake_pending, txd_to_driver};
    swi_sleep_wake_inhibit_control i_dut (.*, .bus_monitor_enable());
    swi_partner i_far (.*);
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
    endtask : cyc
    task automatic wake(input int k);
        txd_valid <= 1'b0;
        edge_mode_one <= (k > 2);
        edge_rising <= (k == 3);
        sleep_req <= 1'b1;
        cyc(1);
        sleep_req <= 1'b0;
        standby_req <= 1'b1;
        cyc(3);
        exp_q.push_back(6'h05);
        if (k != 2) pin_triggered_rouse <= ~pin_triggered_rouse;
        else bus_rouse_pattern <= 1'b1;
        for (n = 0; n < 8 && system_power_enable_oe !== 1'b1; n++)
            @(negedge core_clk);
        if (n == 8) begin
            mismatches++;
            summarize();
        end
        comparisons++;
        if (mode_state !== swi_pkg::SWI_MODE_STANDBY) begin
            mismatches++;
            $display("MISMATCH mode_state exp %0d got %0d",
                swi_pkg::SWI_MODE_STANDBY, mode_state);
        end
        cyc(1);
        exp_q.push_back(6'h3b);
        r = lfsr(r);
        bus_rouse_pattern <= 1'b0;
        wake_flag_clear <= 1'b1;
        bus_rx_level <= r[3];
        cyc(1);
        wake_flag_clear <= 1'b0;
        cyc(2);
        exp_q.push_back({3'h7, r[3], 2'h1});
    endtask : wake
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(negedge core_clk) begin
        if (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            comparisons++;
            if (obs !== e) begin
                mismatches++;
                $display("MISMATCH outputs exp %b got %b", e, obs);
            end
        end
    end
    initial begin
        {arst_n, sleep_req, standby_req, wake_flag_clear} = '0;
        {edge_mode_one, edge_rising, pin_triggered_rouse} = '0;
        {bus_rouse_pattern, txd_in, txd_valid, bus_rx_level} = '0;
        cyc(20);
        arst_n <= 1'b1;
        exp_q.push_back(6'h3d);
        cyc(1);
        repeat (8) begin
            r = lfsr(r);
            {standby_req, bus_rx_level, txd_in, txd_valid} <= r[3:0];
            cyc(2);
            exp_q.push_back({3'h7, r[2], 1'b0, r[0] ? r[1] : 1'b1});
        end
        for (int k = 0; k < 5; k++) wake(k);
        cyc(2);
        summarize();
    end
endmodule : swi_sleep_wake_inhibit_control_bench
`default_nettype wire
